//--- mode_trunk_select.sv
// Keyboard scan, mode control and trunk select logic with register slave
// Operation
// - A pressed key in the driven row reads high on its column sense line.
// - Mode keys are active low, pulling their select line to ground.
// - A mode indicator lights only after the mode circuit has taken up that mode.
// - The reset key drives the processor reset through the pin synchroniser, filter and an output register.
// - Compute gives 0/1, initial condition 1/0 and hold 1/1 on the integrator lines.
// - Repetitive mode alternates initial and compute each time the ramp nears a limit.
// - The mode input stage buffers the keys and picks internal or external control.
// - Trunk multiplexers are enabled only for function address pattern 1100.
// - The five number lines select trunk 0 to 23 as a binary index.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module mode_trunk_select (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // AXI4-Lite slave
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Keyboard pins
   output logic [3:0]       row_drive,
   input  wire logic [5:0]  column_sense,
   input  wire logic [3:0]  mode_key_n,
   input  wire logic [3:0]  external_mode_n,
   input  wire logic        reset_key_n,
   output logic [3:0]       mode_led,
   output logic             processor_reset_n,
   // Ramp comparators and integrator control
   input  wire logic        ramp_at_top,
   input  wire logic        ramp_at_bottom,
   output logic             integrator_first,
   output logic             integrator_second,
   // Trunk multiplexer enables
   output logic [23:0]      trunk_enable
);
   // Decode a byte address into a register index
   function automatic logic [2:0] decode_reg(input logic [15:0] addr);
      logic [2:0] idx;
      idx = trunk_mode_pkg::IDX_NONE;
      if (addr[trunk_mode_pkg::PERIPHERAL_SPACE_BIT]) begin
         case (addr)
            trunk_mode_pkg::ROW_DRIVE_ADDR:    idx = trunk_mode_pkg::IDX_ROW_DRIVE;
            trunk_mode_pkg::COLUMN_SENSE_ADDR: idx = trunk_mode_pkg::IDX_COLUMN_SENSE;
            trunk_mode_pkg::MODE_CTRL_ADDR:    idx = trunk_mode_pkg::IDX_MODE_CTRL;
            trunk_mode_pkg::MODE_STATUS_ADDR:  idx = trunk_mode_pkg::IDX_MODE_STATUS;
            trunk_mode_pkg::TRUNK_SELECT_ADDR: idx = trunk_mode_pkg::IDX_TRUNK_SELECT;
            trunk_mode_pkg::TRUNK_STATUS_ADDR: idx = trunk_mode_pkg::IDX_TRUNK_STATUS;
            default:                           idx = trunk_mode_pkg::IDX_NONE;
         endcase
      end
      return idx;
   endfunction

   // Merge write data into a register under the byte strobes
   function automatic logic [31:0] apply_strobe(input logic [31:0] old_value,
                                                input logic [31:0] new_value,
                                                input logic [3:0]  strobe);
      logic [31:0] merged;
      merged = old_value;
      for (int b = 0; b < 4; b++) begin
         if (strobe[b]) begin
            merged[b*8 +: 8] = new_value[b*8 +: 8];
         end
      end
      return merged;
   endfunction

   // A pin change counts once the second and third stages agree
   function automatic logic [16:0] agree_filter(input logic [16:0] stage2,
                                                input logic [16:0] stage3,
                                                input logic [16:0] held);
      return (stage2 & stage3) | (held & (stage2 | stage3));
   endfunction

   logic                                  rst_s1;
   logic                                  rst_n_sync;
   logic [16:0]                           pin_s1;
   logic [16:0]                           pin_s2;
   logic [16:0]                           pin_s3;
   trunk_mode_pkg::pin_bundle_type        pin_filt;
   trunk_mode_pkg::pin_bundle_type        next_pin_filt;
   logic                                  aw_held;
   logic                                  next_aw_held;
   logic [15:0]                           aw_addr;
   logic [15:0]                           next_aw_addr;
   logic                                  w_held;
   logic                                  next_w_held;
   logic [31:0]                           w_data;
   logic [31:0]                           next_w_data;
   logic [3:0]                            w_strb;
   logic [3:0]                            next_w_strb;
   logic                                  next_awready;
   logic                                  next_wready;
   logic                                  next_bvalid;
   logic [1:0]                            next_bresp;
   logic                                  next_arready;
   logic                                  next_rvalid;
   logic [31:0]                           next_rdata;
   logic [1:0]                            next_rresp;
   logic [1:0]                            row_index;
   logic [1:0]                            next_row_index;
   logic                                  external_select;
   logic                                  next_external_select;
   trunk_mode_pkg::trunk_select_type      trunk_select;
   trunk_mode_pkg::trunk_select_type      next_trunk_select;
   trunk_mode_pkg::mode_state_type        mode_state;
   trunk_mode_pkg::mode_state_type        next_mode_state;
   logic [3:0]                            active_mode_n;
   logic [23:0]                           decoded_enable;
   logic [31:0]                           write_merged;
   logic [2:0]                            write_idx;
   logic [2:0]                            read_idx;

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1     <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_s1     <= 1'b1;
         rst_n_sync <= rst_s1;
      end
   end

   // Pin synchroniser and agreement filter
   assign next_pin_filt = agree_filter(pin_s2, pin_s3, pin_filt);
   always_ff @(posedge clk or negedge rst_n_sync) begin
      // Idle levels: reset key up, ramps clear, mode lines released, no column
      if (!rst_n_sync) begin
         pin_s1   <= 17'h13FC0;
         pin_s2   <= 17'h13FC0;
         pin_s3   <= 17'h13FC0;
         pin_filt <= 17'h13FC0;
      end else begin
         pin_s1   <= {reset_key_n, ramp_at_top, ramp_at_bottom, external_mode_n,
                      mode_key_n, column_sense};
         pin_s2   <= pin_s1;
         pin_s3   <= pin_s2;
         pin_filt <= next_pin_filt;
      end
   end

   // Bus channel handshakes and write decode
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_row_index       = row_index;
      next_external_select = external_select;
      next_trunk_select    = trunk_select;
      write_idx    = decode_reg(aw_addr);
      write_merged = 32'h00000000;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = trunk_mode_pkg::RESP_OKAY;
         case (write_idx)
            trunk_mode_pkg::IDX_ROW_DRIVE: begin
               write_merged   = apply_strobe({30'h0, row_index}, w_data, w_strb);
               next_row_index = write_merged[trunk_mode_pkg::ROW_INDEX_LSB +: 2];
            end
            trunk_mode_pkg::IDX_MODE_CTRL: begin
               write_merged = apply_strobe({31'h0, external_select}, w_data, w_strb);
               next_external_select = write_merged[trunk_mode_pkg::EXTERNAL_SELECT_BIT];
            end
            trunk_mode_pkg::IDX_TRUNK_SELECT: begin
               write_merged      = apply_strobe({23'h0, trunk_select}, w_data, w_strb);
               next_trunk_select = write_merged[8:0];
            end
            trunk_mode_pkg::IDX_COLUMN_SENSE,
            trunk_mode_pkg::IDX_MODE_STATUS,
            trunk_mode_pkg::IDX_TRUNK_STATUS: begin
               write_merged = 32'h00000000; // Read-only, write ignored
            end
            default: begin
               next_bresp = trunk_mode_pkg::RESP_SLVERR;
            end
         endcase
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
   end

   // Read channel and register read mux
   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rdata  = s_axi_rdata;
      next_rresp  = s_axi_rresp;
      read_idx    = decode_reg(s_axi_araddr);
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = trunk_mode_pkg::RESP_OKAY;
         next_rdata  = 32'h00000000;
         case (read_idx)
            trunk_mode_pkg::IDX_ROW_DRIVE:    next_rdata[1:0] = row_index;
            trunk_mode_pkg::IDX_COLUMN_SENSE: next_rdata[5:0] = pin_filt.column_sense;
            trunk_mode_pkg::IDX_MODE_CTRL:    next_rdata[0] = external_select;
            trunk_mode_pkg::IDX_MODE_STATUS: begin
               next_rdata[trunk_mode_pkg::STATUS_STATE_LSB +: 5] = mode_state;
               next_rdata[trunk_mode_pkg::STATUS_FIRST_BIT]      = integrator_first;
               next_rdata[trunk_mode_pkg::STATUS_SECOND_BIT]     = integrator_second;
               next_rdata[trunk_mode_pkg::STATUS_LED_LSB +: 4]   = mode_led;
            end
            trunk_mode_pkg::IDX_TRUNK_SELECT: next_rdata[8:0] = trunk_select;
            trunk_mode_pkg::IDX_TRUNK_STATUS: next_rdata[23:0] = trunk_enable;
            default: next_rresp = trunk_mode_pkg::RESP_SLVERR;
         endcase
      end
      next_arready = !next_rvalid;
   end

   // Bus and control registers
   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         aw_held         <= 1'b0;
         aw_addr         <= 16'h0000;
         w_held          <= 1'b0;
         w_data          <= 32'h00000000;
         w_strb          <= 4'h0;
         s_axi_awready   <= 1'b0;
         s_axi_wready    <= 1'b0;
         s_axi_bvalid    <= 1'b0;
         s_axi_bresp     <= 2'h0;
         s_axi_arready   <= 1'b0;
         s_axi_rvalid    <= 1'b0;
         s_axi_rdata     <= 32'h00000000;
         s_axi_rresp     <= 2'h0;
         row_index       <= trunk_mode_pkg::ROW_INDEX_RESET;
         external_select <= trunk_mode_pkg::EXTERNAL_SELECT_RESET;
         trunk_select    <= {trunk_mode_pkg::NUMBER_RESET, trunk_mode_pkg::FUNC_ADDR_RESET};
      end else begin
         aw_held         <= next_aw_held;
         aw_addr         <= next_aw_addr;
         w_held          <= next_w_held;
         w_data          <= next_w_data;
         w_strb          <= next_w_strb;
         s_axi_awready   <= next_awready;
         s_axi_wready    <= next_wready;
         s_axi_bvalid    <= next_bvalid;
         s_axi_bresp     <= next_bresp;
         s_axi_arready   <= next_arready;
         s_axi_rvalid    <= next_rvalid;
         s_axi_rdata     <= next_rdata;
         s_axi_rresp     <= next_rresp;
         row_index       <= next_row_index;
         external_select <= next_external_select;
         trunk_select    <= next_trunk_select;
      end
   end

   // Mode source select and mode controller
   assign active_mode_n = external_select ? pin_filt.external_mode_n
                                          : pin_filt.mode_key_n;
   always_comb begin
      next_mode_state = mode_state;
      if (!active_mode_n[trunk_mode_pkg::KEY_HOLD]) begin
         next_mode_state = trunk_mode_pkg::MODE_HOLD;
      end else if (!active_mode_n[trunk_mode_pkg::KEY_INITIAL]) begin
         next_mode_state = trunk_mode_pkg::MODE_INITIAL;
      end else if (!active_mode_n[trunk_mode_pkg::KEY_COMPUTE]) begin
         next_mode_state = trunk_mode_pkg::MODE_COMPUTE;
      end else if (!active_mode_n[trunk_mode_pkg::KEY_REPETITIVE]) begin
         if (mode_state != trunk_mode_pkg::MODE_REPET_INIT &&
             mode_state != trunk_mode_pkg::MODE_REPET_RUN) begin
            next_mode_state = trunk_mode_pkg::MODE_REPET_INIT;
         end
      end
      // Ramp limit comparators flip the repetitive cycle
      case (next_mode_state)
         trunk_mode_pkg::MODE_REPET_INIT: begin
            if (pin_filt.ramp_at_bottom) next_mode_state = trunk_mode_pkg::MODE_REPET_RUN;
         end
         trunk_mode_pkg::MODE_REPET_RUN: begin
            if (pin_filt.ramp_at_top) next_mode_state = trunk_mode_pkg::MODE_REPET_INIT;
         end
         default: next_mode_state = next_mode_state;
      endcase
   end

   // Mode state and outputs that follow it one cycle later
   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         mode_state        <= trunk_mode_pkg::MODE_HOLD;
         integrator_first  <= 1'b1;
         integrator_second <= 1'b1;
         mode_led          <= 4'h0;
         row_drive         <= 4'h0;
         processor_reset_n <= 1'b0;
         trunk_enable      <= 24'h000000;
      end else begin
         mode_state <= next_mode_state;
         case (mode_state)
            trunk_mode_pkg::MODE_HOLD: begin
               integrator_first  <= 1'b1;
               integrator_second <= 1'b1;
               mode_led          <= 4'h4;
            end
            trunk_mode_pkg::MODE_INITIAL, trunk_mode_pkg::MODE_REPET_INIT: begin
               integrator_first  <= 1'b1;
               integrator_second <= 1'b0;
               mode_led          <= (mode_state == trunk_mode_pkg::MODE_INITIAL) ? 4'h2 : 4'h8;
            end
            default: begin
               integrator_first  <= 1'b0;
               integrator_second <= 1'b1;
               mode_led          <= (mode_state == trunk_mode_pkg::MODE_COMPUTE) ? 4'h1 : 4'h8;
            end
         endcase
         row_drive         <= 4'h1 << row_index;
         processor_reset_n <= pin_filt.reset_key_n;
         trunk_enable      <= decoded_enable;
      end
   end

   // Trunk channel decode
   trunk_decoder u_trunk_decoder (
      .select (trunk_select),
      .enable (decoded_enable)
   );

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_sync);

   AST_ROW_ONE_HOT: assert property ($past(rst_n_sync) |-> $onehot(row_drive))
      else $error("row drive not one-hot");
   AST_COLUMN_READ: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == trunk_mode_pkg::COLUMN_SENSE_ADDR |=>
      s_axi_rvalid && s_axi_rdata[5:0] == $past(pin_filt.column_sense))
      else $error("column read mismatch");
   AST_KEY_LOW_HOLD: assert property (!external_select &&
      !pin_filt.mode_key_n[trunk_mode_pkg::KEY_HOLD] |=> ##1
      integrator_first && integrator_second)
      else $error("hold key ignored");
   AST_LED_AFTER_MODE: assert property (mode_state == trunk_mode_pkg::MODE_COMPUTE |=>
      mode_led == 4'h1 && !integrator_first)
      else $error("led ahead of mode");
   AST_RESET_KEY: assert property (!pin_filt.reset_key_n |=> !processor_reset_n)
      else $error("reset key not passed");
   AST_INITIAL_OUT: assert property (mode_state == trunk_mode_pkg::MODE_INITIAL |=>
      integrator_first && !integrator_second)
      else $error("initial condition outputs wrong");
   AST_REPET_FLIP: assert property (mode_state == trunk_mode_pkg::MODE_REPET_RUN &&
      pin_filt.ramp_at_top && active_mode_n == 4'hF |=>
      mode_state == trunk_mode_pkg::MODE_REPET_INIT ##1 integrator_first)
      else $error("repetitive cycle not flipped");
   AST_EXTERNAL_SRC: assert property (external_select &&
      !pin_filt.external_mode_n[trunk_mode_pkg::KEY_HOLD] |=>
      mode_state == trunk_mode_pkg::MODE_HOLD)
      else $error("external mode ignored");
   AST_TRUNK_PATTERN: assert property (trunk_enable != 24'h000000 |->
      $past(trunk_select.trunk_function_address) == trunk_mode_pkg::TRUNK_FUNC_PATTERN)
      else $error("trunk enabled off pattern");
   AST_TRUNK_INDEX: assert property (trunk_select.trunk_function_address ==
      trunk_mode_pkg::TRUNK_FUNC_PATTERN &&
      trunk_select.trunk_number_lines <= trunk_mode_pkg::TRUNK_LAST_INDEX |=>
      trunk_enable == 24'h000001 << $past(trunk_select.trunk_number_lines))
      else $error("wrong trunk selected");
   AST_TRUNK_NONE: assert property (trunk_select.trunk_number_lines >
      trunk_mode_pkg::TRUNK_LAST_INDEX |=>
      trunk_enable == 24'h000000)
      else $error("out of range trunk enabled");
   AST_LOW_SPACE: assert property (aw_held && w_held && !s_axi_bvalid &&
      !aw_addr[trunk_mode_pkg::PERIPHERAL_SPACE_BIT] |=>
      s_axi_bvalid && s_axi_bresp == trunk_mode_pkg::RESP_SLVERR)
      else $error("low space write accepted");

   COV_REPET: cover property (mode_state == trunk_mode_pkg::MODE_REPET_RUN ##1
      mode_state == trunk_mode_pkg::MODE_REPET_INIT);
   COV_TRUNK23: cover property (trunk_enable[23]);
   COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
   COV_REFUSED: cover property (s_axi_bvalid && s_axi_bresp == trunk_mode_pkg::RESP_SLVERR);
endmodule

//--- trunk_mode_pkg.sv
// Shared constants and types for the mode and trunk select logic
package trunk_mode_pkg;
   // Register bus widths
   localparam int ADDR_WIDTH = 16;
   localparam int DATA_WIDTH = 32;
   // Peripheral space bit of the host address
   localparam int PERIPHERAL_SPACE_BIT = 15;
   // Register byte addresses (peripheral space bit set)
   localparam logic [15:0] ROW_DRIVE_ADDR    = 16'h8000;
   localparam logic [15:0] COLUMN_SENSE_ADDR = 16'h8004;
   localparam logic [15:0] MODE_CTRL_ADDR    = 16'h8008;
   localparam logic [15:0] MODE_STATUS_ADDR  = 16'h800C;
   localparam logic [15:0] TRUNK_SELECT_ADDR = 16'h8010;
   localparam logic [15:0] TRUNK_STATUS_ADDR = 16'h8014;
   // Register indices returned by the decoder
   localparam logic [2:0] IDX_ROW_DRIVE    = 3'h0;
   localparam logic [2:0] IDX_COLUMN_SENSE = 3'h1;
   localparam logic [2:0] IDX_MODE_CTRL    = 3'h2;
   localparam logic [2:0] IDX_MODE_STATUS  = 3'h3;
   localparam logic [2:0] IDX_TRUNK_SELECT = 3'h4;
   localparam logic [2:0] IDX_TRUNK_STATUS = 3'h5;
   localparam logic [2:0] IDX_NONE         = 3'h7;
   // Field positions
   localparam int ROW_INDEX_LSB      = 0;
   localparam int EXTERNAL_SELECT_BIT = 0;
   localparam int STATUS_STATE_LSB   = 0;
   localparam int STATUS_FIRST_BIT   = 8;
   localparam int STATUS_SECOND_BIT  = 9;
   localparam int STATUS_LED_LSB     = 12;
   localparam int TRUNK_FUNC_LSB     = 0;
   localparam int TRUNK_NUMBER_LSB   = 4;
   // Reset values
   localparam logic [1:0] ROW_INDEX_RESET       = 2'h0;
   localparam logic       EXTERNAL_SELECT_RESET = 1'b0;
   localparam logic [3:0] FUNC_ADDR_RESET       = 4'h0;
   localparam logic [4:0] NUMBER_RESET          = 5'h00;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Matrix and trunk geometry
   localparam int ROW_COUNT    = 4;
   localparam int COLUMN_COUNT = 6;
   localparam int TRUNK_COUNT  = 24;
   localparam logic [3:0] TRUNK_FUNC_PATTERN = 4'hC;
   localparam logic [4:0] TRUNK_LAST_INDEX   = 5'h17;
   // Mode key bit positions
   localparam int KEY_COMPUTE    = 0;
   localparam int KEY_INITIAL    = 1;
   localparam int KEY_HOLD       = 2;
   localparam int KEY_REPETITIVE = 3;
   // Synchronised pin bundle width
   localparam int PIN_WIDTH = 17;

   // Mode controller states, one-hot
   typedef enum logic [4:0] {
      MODE_HOLD         = 5'h01,
      MODE_INITIAL      = 5'h02,
      MODE_COMPUTE      = 5'h04,
      MODE_REPET_INIT   = 5'h08,
      MODE_REPET_RUN    = 5'h10
   } mode_state_type;

   // Latched trunk address and number lines
   typedef struct packed {
      logic [4:0] trunk_number_lines;
      logic [3:0] trunk_function_address;
   } trunk_select_type;

   // External pins passing the synchroniser
   typedef struct packed {
      logic       reset_key_n;
      logic       ramp_at_top;
      logic       ramp_at_bottom;
      logic [3:0] external_mode_n;
      logic [3:0] mode_key_n;
      logic [5:0] column_sense;
   } pin_bundle_type;
endpackage

//--- trunk_decoder.sv
// Trunk multiplexer channel decoder
`timescale 1ns/1ps
module trunk_decoder (
   // Latched address
   input  wire trunk_mode_pkg::trunk_select_type select,
   // One-hot channel enables
   output logic [23:0]                           enable
);
   // Enable one channel only for the trunk pattern and an index in range
   always_comb begin
      enable = 24'h000000;
      if (select.trunk_function_address == trunk_mode_pkg::TRUNK_FUNC_PATTERN) begin
         if (select.trunk_number_lines <= trunk_mode_pkg::TRUNK_LAST_INDEX) begin
            enable = 24'h000001 << select.trunk_number_lines;
         end
      end
   end
endmodule

//--- host_bus_model.sv
// Host model: AXI4-Lite master, one transfer at a time
`timescale 1ns/1ps
module host_bus_model (
   // Clock, handshakes in, requests out
   input  wire logic clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
   output logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0,
   output logic [31:0] s_axi_wdata = '0,
   output logic [3:0]  s_axi_wstrb = 4'hF,
   output logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0,
   output logic        s_axi_arvalid = '0, s_axi_rready = '0
);
   // Write when w is set, else read; each valid held until its own ready
   task automatic go(input bit w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
      do begin
         @(posedge clk);
         {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {s_axi_awvalid, s_axi_wvalid,
            s_axi_arvalid} & ~{s_axi_awready, s_axi_wready, s_axi_arready};
      end while (!(w ? s_axi_bvalid : s_axi_rvalid));
      {s_axi_bready, s_axi_rready} <= 2'h0;
   endtask
endmodule

//--- tb_mode_trunk_select.sv
// Bench comparing the select logic with expected values written into the sequence
`timescale 1ns/1ps
module tb_mode_trunk_select;
   logic clk = 0, reset_n = 0, reset_key_n = 1, ramp_at_top = 0, ramp_at_bottom = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, s_axi_awvalid;
   logic s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, integrator_first;
   logic integrator_second, processor_reset_n;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb, row_drive, mode_led, mode_key_n = 4'hF, external_mode_n = 4'hF;
   logic [5:0] column_sense = 6'h00;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [23:0] trunk_enable;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed = 32'h69F2337D;
   int failures = 0, n_compared = 0, f, n;
   // Design, host model and 40 ns clock
   mode_trunk_select dut (.*);
   host_bus_model host (.*);
   always #20 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [31:0] seen, want);
      n_compared++;
      failures += int'(seen !== want);
      if (seen !== want) $display("wrong value %s expected %h seen %h", what, want, seen);
   endtask
   task automatic wrap_up;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic step(input logic [3:0] key, input logic [1:0] ramp, input logic [6:0] want);
      {mode_key_n, ramp_at_top, ramp_at_bottom} <= {key, ramp};
      repeat (10) @(posedge clk);
      check("mode", {processor_reset_n, integrator_first, integrator_second, mode_led}, want);
   endtask
   // Watchdog
   initial begin
      #500us;
      failures++;
      wrap_up;
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      step(4'hE, 2'h0, 7'h51);
      step(4'hD, 2'h0, 7'h62);
      step(4'hB, 2'h0, 7'h74);
      step(4'h7, 2'h0, 7'h68);
      step(4'hF, 2'h1, 7'h58);
      step(4'hF, 2'h2, 7'h68);
      host.go(1, 16'h8008, 1);
      {external_mode_n, reset_key_n} <= 5'h16;
      step(4'hE, 2'h0, 7'h34);
      reset_key_n <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         column_sense <= seed[5:0];
         f = (i < 2 || seed[9]) ? 12 : seed[3:0];
         n = (i < 2) ? 23 + i : seed[8:4];
         host.go(1, 16'h8000, i % 4);
         host.go(1, 16'h8010, n * 16 + f);
         check("bresp", s_axi_bresp, 0);
         host.go(0, 16'h8004, 0);
         check("column", s_axi_rdata, seed[5:0]);
         check("row", row_drive, 1 << (i % 4));
         check("trunk", trunk_enable, f == 12 && n < 24 ? 1 << n : 0);
         host.go(0, 16'h8014, 0);
         check("trunk status", s_axi_rdata, f == 12 && n < 24 ? 1 << n : 0);
      end
      check("reset release", processor_reset_n, 1);
      host.go(0, 16'h800C, 0);
      check("mode status", s_axi_rdata, 32'h00004301);
      host.go(1, 16'h0008, 0);
      check("low write", s_axi_bresp, 2);
      host.go(0, 16'h0008, 0);
      check("low read", s_axi_rresp, 2);
      host.go(0, 16'h8008, 0);
      check("mode ctrl", s_axi_rdata, 1);
      wrap_up;
   end
endmodule
